// file: verilog/dsa_pkg.sv
// Constants, register map and operation codes of the accumulator datapath.
package dsa_pkg;

  localparam int ACC_W    = 40;
  localparam int WORD_W   = 16;
  localparam int ADDR_W   = 4;
  localparam int CNT_W    = 6;
  localparam int SHIFT_MX = 16;
  localparam int RHI_W    = 24;

  localparam int SIGN_BIT = 39;
  localparam int GUARD_LO = 32;
  localparam int NORM_BIT = 31;
  localparam int HI_LSB   = 16;
  localparam int RND_BIT  = 15;
  localparam int DW_BIT   = 15;

  localparam logic [ADDR_W-1:0] REG_CTRL   = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STAT   = 4'h1;
  localparam logic [ADDR_W-1:0] REG_ACCA_L = 4'h2;
  localparam logic [ADDR_W-1:0] REG_ACCA_H = 4'h3;
  localparam logic [ADDR_W-1:0] REG_ACCA_U = 4'h4;
  localparam logic [ADDR_W-1:0] REG_ACCB_L = 4'h5;
  localparam logic [ADDR_W-1:0] REG_ACCB_H = 4'h6;
  localparam logic [ADDR_W-1:0] REG_ACCB_U = 4'h7;
  localparam logic [ADDR_W-1:0] REG_WBPTR  = 4'h8;

  localparam int CTL_ACC_A_SAT_ENABLE  = 0;
  localparam int CTL_ACC_B_SAT_ENABLE  = 1;
  localparam int CTL_DATA_WRITE_SAT_ENABLE = 2;
  localparam int CTL_SMODE = 3;
  localparam int CTL_RMODE = 4;
  localparam int CTL_CATASTROPHIC_TRAP_ENABLE = 5;
  localparam int CTL_ACC_A_OVF_TRAP_ENABLE = 6;
  localparam int CTL_ACC_B_OVF_TRAP_ENABLE = 7;
  localparam int CTL_W     = 8;

  localparam int STA_OA  = 0;
  localparam int STA_OB  = 1;
  localparam int STA_SA  = 2;
  localparam int STA_SB  = 3;
  localparam int STA_OAB = 4;
  localparam int STA_SAB = 5;

  localparam logic [CTL_W-1:0]  CTRL_RST  = 8'h00;
  localparam logic [WORD_W-1:0] WBPTR_RST = 16'h0000;
  localparam logic [WORD_W-1:0] WBPTR_INC = 16'h0002;

  localparam logic [ACC_W-1:0]  SAT40_POS = 40'h7fffffffff;
  localparam logic [ACC_W-1:0]  SAT40_NEG = 40'h8000000000;
  localparam logic [ACC_W-1:0]  SAT32_POS = 40'h007fffffff;
  localparam logic [ACC_W-1:0]  SAT32_NEG = 40'h0080000000;
  localparam logic [WORD_W-1:0] DW_POS    = 16'h7fff;
  localparam logic [WORD_W-1:0] DW_NEG    = 16'h8000;
  localparam logic [WORD_W-1:0] RND_HALF  = 16'h8000;

  typedef enum logic [3:0] {
    DSA_OP_ADD, DSA_OP_SUB, DSA_OP_LOAD, DSA_OP_NEG, DSA_OP_CLR,
    DSA_OP_MAC, DSA_OP_MSC, DSA_OP_MPY, DSA_OP_MPYN, DSA_OP_ED,
    DSA_OP_SQUARED_DIFFERENCE_ACC_OP
  } dsa_op_e;

  typedef enum logic {DSA_SRC_EXT, DSA_SRC_OTHER} dsa_opnd_e;

  typedef enum logic [1:0] {DSA_SH_ACCA, DSA_SH_ACCB, DSA_SH_XBUS} dsa_shsrc_e;

endpackage : dsa_pkg

// file: verilog/dsa_barrel.sv
// Signed-count barrel shifter: positive counts shift right, negative left.
`timescale 1ns/1ps
module dsa_barrel #(
  parameter int W     = 40,
  parameter int CNT_W = 6,
  parameter int MAX   = 16
) (
  input  wire logic [W-1:0]     data_i,
  input  wire logic [CNT_W-1:0] cnt_i,
  input  wire logic             arith_i,
  output logic      [W-1:0]     res_o
);

  localparam logic [CNT_W-1:0] MAX_C = CNT_W'(MAX);

  wire             left  = cnt_i[CNT_W-1];
  wire [CNT_W-1:0] mag   = left ? CNT_W'(-cnt_i) : cnt_i;
  wire [CNT_W-1:0] amt   = (mag > MAX_C) ? MAX_C : mag;
  wire [W-1:0]     r_ari = W'($signed(data_i) >>> amt);
  wire [W-1:0]     r_log = data_i >> amt;

  // A zero count yields amt of zero, so the operand passes unchanged.
  assign res_o = left ? (data_i << amt) : (arith_i ? r_ari : r_log);

endmodule : dsa_barrel

// file: verilog/dsa_datapath.sv
// Accumulator datapath: adder, saturation, rounding, write-back, shifter.
//
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/1ps
module dsa_datapath (
  input  wire logic                         clk_i,
  input  wire logic                         rst_n_i,
  input  wire logic [dsa_pkg::ADDR_W-1:0]   reg_addr_i,
  input  wire logic [dsa_pkg::WORD_W-1:0]   reg_wdata_i,
  input  wire logic                         reg_wr_i,
  input  wire logic                         reg_rd_i,
  output logic      [dsa_pkg::WORD_W-1:0]   reg_rdata_o,
  input  wire logic                         op_valid_i,
  input  wire dsa_pkg::dsa_op_e             op_code_i,
  input  wire logic                         op_acc_sel_i,
  input  wire dsa_pkg::dsa_opnd_e           op_src_i,
  input  wire logic [dsa_pkg::ACC_W-1:0]    op_operand_i,
  input  wire logic [dsa_pkg::CNT_W-1:0]    op_shift_cnt_i,
  input  wire logic                         op_shift_arith_i,
  input  wire logic                         op_wb_en_i,
  input  wire logic                         op_wb_indirect_i,
  input  wire logic                         st_valid_i,
  input  wire logic                         st_acc_sel_i,
  input  wire logic                         st_round_i,
  input  wire logic [dsa_pkg::WORD_W-1:0]   st_addr_i,
  input  wire logic                         sh_valid_i,
  input  wire dsa_pkg::dsa_shsrc_e          sh_src_i,
  input  wire logic [dsa_pkg::WORD_W-1:0]   sh_xbus_i,
  input  wire logic [dsa_pkg::CNT_W-1:0]    sh_cnt_i,
  input  wire logic                         sh_arith_i,
  output logic      [dsa_pkg::ACC_W-1:0]    sh_result_o,
  output logic      [dsa_pkg::WORD_W-1:0]   sh_word_o,
  output logic                              xw_valid_o,
  output logic      [dsa_pkg::WORD_W-1:0]   xw_addr_o,
  output logic      [dsa_pkg::WORD_W-1:0]   xw_data_o,
  output logic      [dsa_pkg::WORD_W-1:0]   wb_ptr_o,
  output logic      [dsa_pkg::ACC_W-1:0]    acc_a_o,
  output logic      [dsa_pkg::ACC_W-1:0]    acc_b_o,
  output logic                              acc_a_guard_ovf_o,
  output logic                              acc_b_guard_ovf_o,
  output logic                              acc_a_sat_flag_o,
  output logic                              acc_b_sat_flag_o,
  output logic                              any_guard_ovf_o,
  output logic                              any_sat_flag_o,
  output logic                              trap_req_o
);
  import dsa_pkg::*;

  // Operations whose first adder input is forced to zero.
  function automatic logic op_zero_in(input dsa_op_e op);
    return op inside {DSA_OP_LOAD, DSA_OP_NEG, DSA_OP_CLR, DSA_OP_MPY,
                      DSA_OP_MPYN, DSA_OP_ED};
  endfunction : op_zero_in

  // Operations that subtract the second operand.
  function automatic logic op_sub(input dsa_op_e op);
    return op inside {DSA_OP_SUB, DSA_OP_NEG, DSA_OP_MSC, DSA_OP_MPYN};
  endfunction : op_sub

  // Operations allowed to write back the other accumulator.
  function automatic logic op_wb_ok(input dsa_op_e op);
    return op inside {DSA_OP_CLR, DSA_OP_MAC, DSA_OP_MSC};
  endfunction : op_wb_ok

  // High word, optionally rounded, kept with its sign-extended guard bits.
  function automatic logic [RHI_W-1:0] round_hi(input logic [ACC_W-1:0] acc,
                                                input logic biased,
                                                input logic en);
    logic inc;
    inc = en & acc[RND_BIT];
    if (!biased && acc[RND_BIT-1:0] == RND_HALF[RND_BIT-1:0]) begin
      inc = en & acc[RND_BIT] & acc[HI_LSB];
    end
    return acc[ACC_W-1:HI_LSB] + RHI_W'(inc);
  endfunction : round_hi

  // Clamp a rounded word to the 1.15 range, sign taken from the source.
  function automatic logic [WORD_W-1:0] dw_sat(input logic [RHI_W-1:0] r,
                                               input logic sign,
                                               input logic en);
    logic [WORD_W-1:0] res;
    res = r[WORD_W-1:0];
    if (en && !sign && (r[RHI_W-1:DW_BIT] != '0)) begin
      res = DW_POS;
    end else if (en && sign && (r[RHI_W-1:DW_BIT] != '1)) begin
      res = DW_NEG;
    end
    return res;
  endfunction : dw_sat

  logic [ACC_W-1:0]  acc_a;
  logic [ACC_W-1:0]  acc_b;
  logic [CTL_W-1:0]  ctrl;
  logic [WORD_W-1:0] wb_ptr;
  logic              guard_a;
  logic              guard_b;
  logic              sat_a;
  logic              sat_b;
  logic              trap_req;
  logic              xw_valid;
  logic [WORD_W-1:0] xw_addr;
  logic [WORD_W-1:0] xw_data;
  logic [WORD_W-1:0] rdata;
  logic [ACC_W-1:0]  sh_result;
  logic [WORD_W-1:0] sh_word;

  // Control fields.
  wire sat_en_a  = ctrl[CTL_ACC_A_SAT_ENABLE];
  wire sat_en_b  = ctrl[CTL_ACC_B_SAT_ENABLE];
  wire dw_sat_en = ctrl[CTL_DATA_WRITE_SAT_ENABLE];
  wire super_md  = ctrl[CTL_SMODE];
  wire biased    = ctrl[CTL_RMODE];
  wire catastrophic_trap_enable     = ctrl[CTL_CATASTROPHIC_TRAP_ENABLE];

  // Operand selection and scaling.
  wire [ACC_W-1:0] acc_tgt  = op_acc_sel_i ? acc_b : acc_a;
  wire [ACC_W-1:0] acc_oth  = op_acc_sel_i ? acc_a : acc_b;
  wire [ACC_W-1:0] opnd_raw = (op_src_i == DSA_SRC_OTHER) ? acc_oth
                                                          : op_operand_i;
  wire [ACC_W-1:0] opnd_sh;

  dsa_barrel #(.W(ACC_W), .CNT_W(CNT_W), .MAX(SHIFT_MX)) u_op_shift (
    .data_i  (opnd_raw),
    .cnt_i   (op_shift_cnt_i),
    .arith_i (op_shift_arith_i),
    .res_o   (opnd_sh)
  );

  // Adder and subtracter.
  wire             do_sub = op_sub(op_code_i);
  wire [ACC_W-1:0] a_in   = op_zero_in(op_code_i) ? '0 : acc_tgt;
  wire [ACC_W-1:0] b_raw  = (op_code_i == DSA_OP_CLR) ? '0 : opnd_sh;
  wire [ACC_W-1:0] b_in   = do_sub ? ~b_raw : b_raw;
  wire [ACC_W-1:0] cin    = ACC_W'(do_sub);
  wire [ACC_W-1:0] sum    = a_in + b_in + cin;

  // Overflow detection.
  wire cat_ovf  = (a_in[SIGN_BIT] == b_in[SIGN_BIT]) &&
                  (sum[SIGN_BIT] != a_in[SIGN_BIT]);
  wire guard_ov = !((&sum[SIGN_BIT:GUARD_LO]) ||
                    (~|sum[SIGN_BIT:GUARD_LO]));
  wire norm_ov  = cat_ov_or_norm(sum, cat_ovf);
  wire true_neg = cat_ovf ? a_in[SIGN_BIT] : sum[SIGN_BIT];

  function automatic logic cat_ov_or_norm(input logic [ACC_W-1:0] s,
                                          input logic cat);
    return cat || !((&s[SIGN_BIT:NORM_BIT]) || (~|s[SIGN_BIT:NORM_BIT]));
  endfunction : cat_ov_or_norm

  // Saturation decision.
  wire             sat_en   = op_acc_sel_i ? sat_en_b : sat_en_a;
  wire             do_sat   = sat_en && (super_md ? cat_ovf : norm_ov);
  wire [ACC_W-1:0] sat40    = true_neg ? SAT40_NEG : SAT40_POS;
  wire [ACC_W-1:0] sat32    = true_neg ? SAT32_NEG : SAT32_POS;
  wire [ACC_W-1:0] sat_val  = super_md ? sat40 : sat32;
  // With saturation off the sum wraps through unchanged.
  wire [ACC_W-1:0] next_acc = do_sat ? sat_val : sum;
  wire             sat_set  = sat_en ? do_sat : cat_ovf;
  wire             guard_nw = (sat_en && !super_md) ? 1'b0 : guard_ov;
  wire             ovf_te   = op_acc_sel_i ? ctrl[CTL_ACC_B_OVF_TRAP_ENABLE]
                                           : ctrl[CTL_ACC_A_OVF_TRAP_ENABLE];
  wire             next_trap = op_valid_i &&
                               ((guard_nw && ovf_te) ||
                                (!sat_en && cat_ovf && catastrophic_trap_enable));

  // Write-back of the other accumulator, always rounded.
  wire             wb_go   = op_valid_i && op_wb_en_i &&
                             op_wb_ok(op_code_i);
  wire [WORD_W-1:0] wb_data = dw_sat(round_hi(acc_oth, biased, 1'b1),
                                     acc_oth[SIGN_BIT], dw_sat_en);
  wire             wb_dir  = wb_go && !op_wb_indirect_i;
  wire             wb_ind  = wb_go && op_wb_indirect_i;

  // Accumulator store; yields to a write-back in the same cycle.
  wire             st_go   = st_valid_i && !wb_go;
  wire [ACC_W-1:0] st_acc  = st_acc_sel_i ? acc_b : acc_a;
  wire [WORD_W-1:0] st_data = dw_sat(round_hi(st_acc, biased, st_round_i),
                                     st_acc[SIGN_BIT], dw_sat_en);

  wire             next_xw_valid = wb_ind || st_go;
  wire [WORD_W-1:0] next_xw_addr = wb_ind ? wb_ptr : st_addr_i;
  wire [WORD_W-1:0] next_xw_data = wb_ind ? wb_data : st_data;

  wire             ptr_wr = reg_wr_i && (reg_addr_i == REG_WBPTR);
  wire [WORD_W-1:0] next_wb_ptr = wb_dir ? wb_data :
                                  wb_ind ? wb_ptr + WBPTR_INC :
                                  ptr_wr ? reg_wdata_i : wb_ptr;

  // Status flags; a hardware set wins over a software clear.
  wire upd_a    = op_valid_i && !op_acc_sel_i;
  wire upd_b    = op_valid_i && op_acc_sel_i;
  wire stat_wr  = reg_wr_i && (reg_addr_i == REG_STAT);
  wire clr_sa   = stat_wr && !reg_wdata_i[STA_SA];
  wire clr_sb   = stat_wr && !reg_wdata_i[STA_SB];
  wire next_sat_a = (upd_a && sat_set) || (sat_a && !clr_sa);
  wire next_sat_b = (upd_b && sat_set) || (sat_b && !clr_sb);
  wire next_grd_a = upd_a ? guard_nw : guard_a;
  wire next_grd_b = upd_b ? guard_nw : guard_b;
  wire any_grd    = guard_a | guard_b;
  wire any_sat    = sat_a | sat_b;

  wire ctrl_wr = reg_wr_i && (reg_addr_i == REG_CTRL);

  // Register read decode.
  logic [WORD_W-1:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    unique case (reg_addr_i)
      REG_CTRL:   rd_mux = WORD_W'(ctrl);
      REG_STAT:   begin
        rd_mux[STA_OA]  = guard_a;
        rd_mux[STA_OB]  = guard_b;
        rd_mux[STA_SA]  = sat_a;
        rd_mux[STA_SB]  = sat_b;
        rd_mux[STA_OAB] = any_grd;
        rd_mux[STA_SAB] = any_sat;
      end
      REG_ACCA_L: rd_mux = acc_a[WORD_W-1:0];
      REG_ACCA_H: rd_mux = acc_a[NORM_BIT:HI_LSB];
      REG_ACCA_U: rd_mux = WORD_W'(acc_a[SIGN_BIT:GUARD_LO]);
      REG_ACCB_L: rd_mux = acc_b[WORD_W-1:0];
      REG_ACCB_H: rd_mux = acc_b[NORM_BIT:HI_LSB];
      REG_ACCB_U: rd_mux = WORD_W'(acc_b[SIGN_BIT:GUARD_LO]);
      REG_WBPTR:  rd_mux = wb_ptr;
      default:    rd_mux = '0;
    endcase
  end

  // Stand-alone shift unit.
  wire             sh_right = !sh_cnt_i[CNT_W-1];
  wire [ACC_W-1:0] x_right  = {{(ACC_W-NORM_BIT-1){sh_arith_i &
                                sh_xbus_i[WORD_W-1]}},
                               sh_xbus_i, {HI_LSB{1'b0}}};
  wire [ACC_W-1:0] x_left   = {{(ACC_W-WORD_W){1'b0}}, sh_xbus_i};
  wire [ACC_W-1:0] sh_in    = (sh_src_i == DSA_SH_ACCA) ? acc_a :
                              (sh_src_i == DSA_SH_ACCB) ? acc_b :
                              (sh_right ? x_right : x_left);
  wire [ACC_W-1:0] sh_out;

  dsa_barrel #(.W(ACC_W), .CNT_W(CNT_W), .MAX(SHIFT_MX)) u_sh_unit (
    .data_i  (sh_in),
    .cnt_i   (sh_cnt_i),
    .arith_i (sh_arith_i),
    .res_o   (sh_out)
  );

  // 40-bit result for the DSP path, 16-bit word for the MCU path.
  wire [WORD_W-1:0] sh_mcu = sh_right ? sh_out[NORM_BIT:HI_LSB]
                                      : sh_out[WORD_W-1:0];

  // Accumulators.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_a <= '0;
      acc_b <= '0;
    end else begin
      if (upd_a) acc_a <= next_acc;
      if (upd_b) acc_b <= next_acc;
    end
  end

  // Flags and trap request.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      guard_a  <= 1'b0;
      guard_b  <= 1'b0;
      sat_a    <= 1'b0;
      sat_b    <= 1'b0;
      trap_req <= 1'b0;
    end else begin
      guard_a  <= next_grd_a;
      guard_b  <= next_grd_b;
      sat_a    <= next_sat_a;
      sat_b    <= next_sat_b;
      trap_req <= next_trap;
    end
  end

  // Control, pointer and data bus write.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl     <= CTRL_RST;
      wb_ptr   <= WBPTR_RST;
      xw_valid <= 1'b0;
      xw_addr  <= '0;
      xw_data  <= '0;
    end else begin
      if (ctrl_wr) ctrl <= reg_wdata_i[CTL_W-1:0];
      wb_ptr   <= next_wb_ptr;
      xw_valid <= next_xw_valid;
      xw_addr  <= next_xw_addr;
      xw_data  <= next_xw_data;
    end
  end

  // Read data and shift results.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata     <= '0;
      sh_result <= '0;
      sh_word   <= '0;
    end else begin
      rdata <= reg_rd_i ? rd_mux : '0;
      if (sh_valid_i) begin
        sh_result <= sh_out;
        sh_word   <= sh_mcu;
      end
    end
  end

  assign reg_rdata_o       = rdata;
  assign sh_result_o       = sh_result;
  assign sh_word_o         = sh_word;
  assign xw_valid_o        = xw_valid;
  assign xw_addr_o         = xw_addr;
  assign xw_data_o         = xw_data;
  assign wb_ptr_o          = wb_ptr;
  assign acc_a_o           = acc_a;
  assign acc_b_o           = acc_b;
  assign acc_a_guard_ovf_o = guard_a;
  assign acc_b_guard_ovf_o = guard_b;
  assign acc_a_sat_flag_o  = sat_a;
  assign acc_b_sat_flag_o  = sat_b;
  assign any_guard_ovf_o   = any_grd;
  assign any_sat_flag_o    = any_sat;
  assign trap_req_o        = trap_req;

endmodule : dsa_datapath

// file: tb/dsa_datapath_properties.sv
// Concurrent checks on the ports of the accumulator datapath.
`timescale 1ns/1ps
module dsa_datapath_properties (
  input wire logic               clk_i,
  input wire logic               rst_n_i,
  input wire logic [3:0]         reg_addr_i,
  input wire logic [15:0]        reg_wdata_i,
  input wire logic               reg_wr_i,
  input wire logic               op_valid_i,
  input wire dsa_pkg::dsa_op_e    op_code_i,
  input wire logic               op_wb_en_i,
  input wire logic               op_wb_indirect_i,
  input wire logic               st_valid_i,
  input wire logic [15:0]        st_addr_i,
  input wire logic               sh_valid_i,
  input wire dsa_pkg::dsa_shsrc_e sh_src_i,
  input wire logic [15:0]        sh_xbus_i,
  input wire logic [5:0]         sh_cnt_i,
  input wire logic [15:0]        sh_word_o,
  input wire logic               xw_valid_o,
  input wire logic [15:0]        xw_addr_o,
  input wire logic [15:0]        wb_ptr_o,
  input wire logic [39:0]        acc_a_o,
  input wire logic               acc_a_guard_ovf_o,
  input wire logic               acc_b_guard_ovf_o,
  input wire logic               acc_a_sat_flag_o,
  input wire logic               acc_b_sat_flag_o,
  input wire logic               any_guard_ovf_o,
  input wire logic               any_sat_flag_o,
  input wire logic               trap_req_o
);
  import dsa_pkg::*;
  wire logic wb_go = op_valid_i && op_wb_en_i &&
    (op_code_i inside {DSA_OP_CLR, DSA_OP_MAC, DSA_OP_MSC});
  wire logic no_wb = op_valid_i && op_wb_en_i && !st_valid_i &&
    (op_code_i inside {DSA_OP_MPY, DSA_OP_MPYN, DSA_OP_ED, DSA_OP_SQUARED_DIFFERENCE_ACC_OP});
  wire logic clr_a = reg_wr_i && reg_addr_i == REG_STAT &&
    !reg_wdata_i[STA_SA];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  chk_any_guard: assert property (
    any_guard_ovf_o == (acc_a_guard_ovf_o | acc_b_guard_ovf_o))
    else $error("combined guard bit wrong");
  chk_any_sat: assert property (
    any_sat_flag_o == (acc_a_sat_flag_o | acc_b_sat_flag_o))
    else $error("combined saturation bit wrong");
  chk_sat_sticky: assert property (
    acc_a_sat_flag_o && !clr_a |=> acc_a_sat_flag_o)
    else $error("saturation flag dropped by hardware");
  chk_sat_clear: assert property (
    clr_a && !op_valid_i |=> !acc_a_sat_flag_o)
    else $error("saturation flag not cleared");
  chk_guard_keep: assert property (
    !op_valid_i |=> $stable(acc_a_guard_ovf_o))
    else $error("guard flag moved without an operation");
  chk_guard_bits: assert property (
    acc_a_guard_ovf_o |-> !(acc_a_o[39:32] inside {8'h00, 8'hff}))
    else $error("guard flag with equal guard bits");
  chk_wb_indirect: assert property (
    wb_go && op_wb_indirect_i |=> xw_valid_o &&
    xw_addr_o == $past(wb_ptr_o) && wb_ptr_o == $past(wb_ptr_o) + 16'h0002)
    else $error("indirect write-back wrong");
  chk_wb_direct: assert property (
    wb_go && !op_wb_indirect_i |=> !xw_valid_o)
    else $error("direct write-back reached data space");
  chk_wb_refused: assert property (
    no_wb |=> !xw_valid_o)
    else $error("write-back from excluded operation");
  chk_store_lat: assert property (
    st_valid_i && !wb_go |=> xw_valid_o && xw_addr_o == $past(st_addr_i))
    else $error("store not written");
  chk_trap_src: assert property (
    trap_req_o |-> $past(op_valid_i))
    else $error("trap request without operation");
  chk_shift_zero: assert property (
    sh_valid_i && sh_src_i == DSA_SH_XBUS && sh_cnt_i == 6'h00 |=>
    sh_word_o == $past(sh_xbus_i))
    else $error("zero shift changed operand");
  cov_wb: cover property (wb_go ##1 xw_valid_o);
  cov_trap: cover property (trap_req_o);
  cov_sat: cover property ($rose(acc_a_sat_flag_o));
endmodule : dsa_datapath_properties

bind dsa_datapath dsa_datapath_properties chk_u (.*);

// file: tb/dsa_xmem.sv
// Data-space memory model that takes the X-bus writes.
`timescale 1ns/1ps
module dsa_xmem (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        xw_valid_i,
  input  wire logic [15:0] xw_addr_i,
  input  wire logic [15:0] xw_data_i,
  output logic      [15:0] wr_cnt_o
);
  logic [15:0] mem [0:15];
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_cnt_o <= 16'h0000;
    end else if (xw_valid_i) begin
      mem[xw_addr_i[4:1]] <= xw_data_i;
      wr_cnt_o <= wr_cnt_o + 16'h0001;
    end
  end
endmodule : dsa_xmem

// file: tb/dsa_datapath_tb.sv
// Self-checking bench for the accumulator datapath.
`timescale 1ns/1ps
module dsa_datapath_tb;
  import dsa_pkg::*;
  logic clk_i, rst_n_i, reg_wr_i, reg_rd_i, op_valid_i, op_acc_sel_i;
  logic op_shift_arith_i, op_wb_en_i, op_wb_indirect_i, st_valid_i;
  logic st_acc_sel_i, st_round_i, sh_valid_i, sh_arith_i, xw_valid_o;
  logic trap_req_o, acc_a_guard_ovf_o, acc_b_guard_ovf_o, any_guard_ovf_o;
  logic acc_a_sat_flag_o, acc_b_sat_flag_o, any_sat_flag_o;
  logic [3:0]  reg_addr_i;
  logic [15:0] reg_wdata_i, reg_rdata_o, st_addr_i, sh_xbus_i, sh_word_o;
  logic [15:0] xw_addr_o, xw_data_o, wb_ptr_o, wr_cnt;
  logic [39:0] op_operand_i, sh_result_o, acc_a_o, acc_b_o;
  logic [5:0]  op_shift_cnt_i, sh_cnt_i;
  dsa_op_e     op_code_i;
  dsa_opnd_e   op_src_i;
  dsa_shsrc_e  sh_src_i;
  int          error_cnt, tests_run, cyc;
  dsa_datapath dut_u (.*);
  dsa_xmem xmem_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .xw_valid_i(xw_valid_o),
    .xw_addr_i(xw_addr_o), .xw_data_i(xw_data_o), .wr_cnt_o(wr_cnt));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic print_verdict();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      print_verdict();
    end
  end
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    @(negedge clk_i);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    @(negedge clk_i);
    chk(reg_rdata_o, e);
  endtask : rd
  task automatic op(input dsa_op_e c, input logic b, input logic [39:0] v,
                    input logic [1:0] wb = 2'b00,
                    input dsa_opnd_e s = DSA_SRC_EXT);
    @(posedge clk_i);
    op_valid_i <= 1'b1;
    op_code_i <= c;
    op_acc_sel_i <= b;
    op_operand_i <= v;
    {op_wb_en_i, op_wb_indirect_i} <= wb;
    op_src_i <= s;
    @(posedge clk_i);
    op_valid_i <= 1'b0;
    @(negedge clk_i);
  endtask : op
  task automatic st(input logic r, input logic [15:0] e);
    @(posedge clk_i);
    st_valid_i <= 1'b1;
    st_round_i <= r;
    st_addr_i <= 16'h0040;
    @(posedge clk_i);
    st_valid_i <= 1'b0;
    @(negedge clk_i);
    chk(xw_valid_o, 1'b1);
    chk(xw_data_o, e);
  endtask : st
  task automatic sh(input dsa_shsrc_e s, input logic [15:0] x,
                    input logic [5:0] n, input logic ar, input logic [39:0] e);
    @(posedge clk_i);
    sh_valid_i <= 1'b1;
    sh_src_i <= s;
    sh_xbus_i <= x;
    sh_cnt_i <= n;
    sh_arith_i <= ar;
    @(posedge clk_i);
    sh_valid_i <= 1'b0;
    @(negedge clk_i);
    chk(sh_result_o, e);
  endtask : sh
  task automatic t_reset();
    rd(REG_CTRL, 16'h0000);
    rd(REG_STAT, 16'h0000);
    rd(REG_WBPTR, 16'h0000);
    rd(4'hf, 16'h0000);
  endtask : t_reset
  task automatic t_adder();
    op(DSA_OP_LOAD, 1'b0, 40'h00ffffffff);
    op(DSA_OP_ADD, 1'b0, 40'h0000000001);
    chk(acc_a_o, 40'h0100000000);
    chk(acc_a_guard_ovf_o, 1'b1);
    chk(any_guard_ovf_o, 1'b1);
    chk(trap_req_o, 1'b0);
    wr(REG_CTRL, 16'h0040);
    op(DSA_OP_ADD, 1'b0, 40'h0000000000);
    chk(trap_req_o, 1'b1);
    op(DSA_OP_SUB, 1'b0, 40'h0000000001);
    chk(acc_a_o, 40'h00ffffffff);
    chk(acc_a_guard_ovf_o, 1'b0);
    op(DSA_OP_ADD, 1'b1, 40'h0, 2'b00, DSA_SRC_OTHER);
    chk(acc_b_o, 40'h00ffffffff);
    op(DSA_OP_MPYN, 1'b0, 40'h0000000001);
    chk(acc_a_o, 40'hffffffffff);
  endtask : t_adder
  task automatic t_catas();
    wr(REG_CTRL, 16'h0020);
    op(DSA_OP_LOAD, 1'b0, 40'h7fffffffff);
    op(DSA_OP_ADD, 1'b0, 40'h0000000001);
    chk(acc_a_o, 40'h8000000000);
    chk(acc_a_sat_flag_o, 1'b1);
    chk(trap_req_o, 1'b1);
    rd(REG_STAT, 16'h0035);
    op(DSA_OP_LOAD, 1'b0, 40'h0);
    chk(any_sat_flag_o, 1'b1);
    wr(REG_STAT, 16'h0000);
    chk(acc_a_sat_flag_o, 1'b0);
  endtask : t_catas
  task automatic t_super();
    wr(REG_CTRL, 16'h0009);
    op(DSA_OP_LOAD, 1'b0, 40'h7fffffffff);
    op(DSA_OP_ADD, 1'b0, 40'h0000000001);
    chk(acc_a_o, SAT40_POS);
    chk(acc_a_sat_flag_o, 1'b1);
    rd(REG_ACCA_U, 16'h007f);
    op(DSA_OP_LOAD, 1'b0, 40'h8000000000);
    op(DSA_OP_SUB, 1'b0, 40'h0000000001);
    chk(acc_a_o, SAT40_NEG);
    wr(REG_STAT, 16'h0000);
  endtask : t_super
  task automatic t_normal();
    wr(REG_CTRL, 16'h0001);
    op(DSA_OP_LOAD, 1'b0, 40'h007fffffff);
    op(DSA_OP_ADD, 1'b0, 40'h0000000001);
    chk(acc_a_o, SAT32_POS);
    chk(acc_a_sat_flag_o, 1'b1);
    chk(acc_a_guard_ovf_o, 1'b0);
    op(DSA_OP_LOAD, 1'b0, 40'hff80000000);
    op(DSA_OP_SUB, 1'b0, 40'h0000000001);
    chk(acc_a_o, SAT32_NEG);
    wr(REG_STAT, 16'h0000);
  endtask : t_normal
  task automatic t_round();
    wr(REG_CTRL, 16'h0010);
    op(DSA_OP_LOAD, 1'b1, 40'h0012348000);
    st(1'b1, 16'h1235);
    wr(REG_CTRL, 16'h0000);
    st(1'b1, 16'h1234);
    op(DSA_OP_LOAD, 1'b1, 40'h0012358000);
    st(1'b1, 16'h1236);
    st(1'b0, 16'h1235);
    op(DSA_OP_LOAD, 1'b1, 40'h0012348001);
    st(1'b1, 16'h1235);
  endtask : t_round
  task automatic t_dwsat();
    wr(REG_CTRL, 16'h0004);
    op(DSA_OP_LOAD, 1'b1, 40'h0123450000);
    st(1'b0, DW_POS);
    chk(acc_b_o, 40'h0123450000);
    chk(acc_b_guard_ovf_o, 1'b1);
    op(DSA_OP_LOAD, 1'b1, 40'hfe00000000);
    st(1'b0, DW_NEG);
    wr(REG_CTRL, 16'h0000);
    st(1'b0, 16'h0000);
  endtask : t_dwsat
  task automatic t_wb();
    logic [15:0] n;
    wr(REG_WBPTR, 16'h0010);
    wr(REG_CTRL, 16'h0010);
    op(DSA_OP_LOAD, 1'b1, 40'h0012348000);
    op(DSA_OP_MAC, 1'b0, 40'h0, 2'b11);
    chk(xw_addr_o, 16'h0010);
    chk(wb_ptr_o, 16'h0012);
    @(negedge clk_i);
    chk(xmem_u.mem[8], 16'h1235);
    n = wr_cnt;
    op(DSA_OP_MPY, 1'b0, 40'h0, 2'b11);
    chk(xw_valid_o, 1'b0);
    @(negedge clk_i);
    chk(wr_cnt, n);
    op(DSA_OP_CLR, 1'b0, 40'h0, 2'b10);
    rd(REG_WBPTR, 16'h1235);
    chk(acc_a_o, 40'h0);
    op(DSA_OP_MSC, 1'b0, 40'h0000000001);
    chk(acc_a_o, 40'hffffffffff);
  endtask : t_wb
  task automatic t_shift();
    sh(DSA_SH_XBUS, 16'h8000, 6'h04, 1'b1, 40'hfff8000000);
    sh(DSA_SH_XBUS, 16'h8000, 6'h04, 1'b0, 40'h0008000000);
    chk(sh_word_o, 16'h0800);
    sh(DSA_SH_XBUS, 16'h8000, 6'h3c, 1'b0, 40'h0000080000);
    sh(DSA_SH_XBUS, 16'h1234, 6'h00, 1'b0, 40'h0012340000);
    sh(DSA_SH_XBUS, 16'h0001, 6'h10, 1'b0, 40'h0000000001);
    sh(DSA_SH_XBUS, 16'h0001, 6'h30, 1'b0, 40'h0000010000);
    op(DSA_OP_LOAD, 1'b0, 40'h00000000f0);
    sh(DSA_SH_ACCA, 16'h0000, 6'h04, 1'b0, 40'h000000000f);
  endtask : t_shift
  initial begin
    {reg_wr_i, reg_rd_i, op_valid_i, st_valid_i, sh_valid_i} = '0;
    {op_acc_sel_i, op_shift_arith_i, op_wb_en_i, op_wb_indirect_i} = '0;
    {st_round_i, sh_arith_i, reg_addr_i, reg_wdata_i, st_addr_i} = '0;
    {sh_xbus_i, op_operand_i, op_shift_cnt_i, sh_cnt_i} = '0;
    st_acc_sel_i = 1'b1;
    op_code_i = DSA_OP_ADD;
    op_src_i = DSA_SRC_EXT;
    sh_src_i = DSA_SH_XBUS;
    rst_n_i = 1'b0;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_adder();
    t_catas();
    t_super();
    t_normal();
    t_round();
    t_dwsat();
    t_wb();
    t_shift();
    print_verdict();
  end
endmodule : dsa_datapath_tb
